/* File: include/psc_map.vh */
// register indices, field positions and reset values of the page/crc bank
`ifndef PSC_MAP_VH
`define PSC_MAP_VH

`define PSC_AXI_AW          12
`define PSC_IDX_PAGE        8'h20
`define PSC_IDX_CRC_HI      8'h21
`define PSC_IDX_CRC_LO      8'h22
`define PSC_IDX_CONFIG      8'h30
`define PSC_IDX_STATUS      8'h31
`define PSC_IDX_IRQ_STAT    8'h32
`define PSC_IDX_IRQ_MASK    8'h33

`define PSC_PAGE_OVR_BIT    7
`define PSC_PAGE_NUM_HI     1
`define PSC_PAGE_NUM_LO     0
`define PSC_PAGE_RST        8'h00
`define PSC_CRC_RST         8'hff
`define PSC_CFG_REV_BIT     0
`define PSC_CFG_RST         8'h00
`define PSC_STAT_DONE_BIT   0

`define PSC_EV_CRC_DONE     0
`define PSC_EV_PAGED        1
`define PSC_EV_W            2
`define PSC_EV_RST          2'b00

`define PSC_ADDR_W          6
`define PSC_LOW_ADDR_W      4
`define PSC_RESP_OKAY       2'b00
`define PSC_RESP_SLVERR     2'b10

`endif

/* File: src/psc_crc_view.v */
// crc result byte registers with optional bit order reversal
`timescale 1ns/100ps
`default_nettype none
`include "psc_map.vh"

module psc_crc_view (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire [15:0] crc_value,
  input  wire        bit_order_reverse,
  output reg  [7:0]  crc_high_byte_r,
  output reg  [7:0]  crc_low_byte_r
);

  wire [7:0] high_rev;
  wire [7:0] low_rev;

  // reversal stays inside each byte; the bytes never swap registers
  genvar i;
  generate
    for (i = 0; i < 8; i = i + 1) begin : g_rev
      assign high_rev[i] = crc_value[15 - i];
      assign low_rev[i]  = crc_value[7 - i];
    end
  endgenerate

  always @(posedge aclk) begin
    if (!aresetn) begin
      crc_high_byte_r <= `PSC_CRC_RST;
      crc_low_byte_r  <= `PSC_CRC_RST;
    end else begin
      crc_high_byte_r <= bit_order_reverse ? high_rev
                                           : crc_value[15:8];
      crc_low_byte_r  <= bit_order_reverse ? low_rev
                                           : crc_value[7:0];
    end
  end

endmodule
`default_nettype wire

/* File: src/psc_axil_slave.v */
// axi4-lite slave front end: one write and one read in flight
`timescale 1ns/100ps
`default_nettype none
`include "psc_map.vh"

module psc_axil_slave (
  input  wire                     aclk,
  input  wire                     aresetn,
  input  wire [`PSC_AXI_AW-1:0]   s_axi_awaddr,
  input  wire                     s_axi_awvalid,
  output reg                      s_axi_awready,
  input  wire [31:0]              s_axi_wdata,
  input  wire [3:0]               s_axi_wstrb,
  input  wire                     s_axi_wvalid,
  output reg                      s_axi_wready,
  output reg  [1:0]               s_axi_bresp,
  output reg                      s_axi_bvalid,
  input  wire                     s_axi_bready,
  input  wire [`PSC_AXI_AW-1:0]   s_axi_araddr,
  input  wire                     s_axi_arvalid,
  output reg                      s_axi_arready,
  output reg  [31:0]              s_axi_rdata,
  output reg  [1:0]               s_axi_rresp,
  output reg                      s_axi_rvalid,
  input  wire                     s_axi_rready,
  output wire                     wr_en,
  output reg  [`PSC_AXI_AW-1:0]   wr_addr_r,
  output reg  [31:0]              wr_data_r,
  output reg  [3:0]               wr_strb_r,
  input  wire                     wr_ok,
  output reg  [`PSC_AXI_AW-1:0]   rd_addr_r,
  input  wire [31:0]              rd_data,
  input  wire                     rd_ok
);

  reg aw_full_r;
  reg w_full_r;
  reg rd_pend_r;

  // the write fires only once both halves are held and no response waits
  assign wr_en = aw_full_r & w_full_r & ~s_axi_bvalid;

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `PSC_RESP_OKAY;
      aw_full_r     <= 1'b0;
      w_full_r      <= 1'b0;
      wr_addr_r     <= {`PSC_AXI_AW{1'b0}};
      wr_data_r     <= 32'h0000_0000;
      wr_strb_r     <= 4'h0;
    end else begin
      s_axi_awready <= s_axi_awvalid & ~s_axi_awready & ~aw_full_r;
      s_axi_wready  <= s_axi_wvalid & ~s_axi_wready & ~w_full_r;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_full_r <= 1'b1;
        wr_addr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_full_r  <= 1'b1;
        wr_data_r <= s_axi_wdata;
        wr_strb_r <= s_axi_wstrb;
      end
      if (wr_en) begin
        aw_full_r    <= 1'b0;
        w_full_r     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? `PSC_RESP_OKAY : `PSC_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `PSC_RESP_OKAY;
      rd_pend_r     <= 1'b0;
      rd_addr_r     <= {`PSC_AXI_AW{1'b0}};
    end else begin
      s_axi_arready <= s_axi_arvalid & ~s_axi_arready & ~rd_pend_r
                       & ~s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        rd_pend_r <= 1'b1;
        rd_addr_r <= s_axi_araddr;
      end
      if (rd_pend_r) begin
        rd_pend_r    <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_ok ? rd_data : 32'h0000_0000;
        s_axi_rresp  <= rd_ok ? `PSC_RESP_OKAY : `PSC_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule
`default_nettype wire

/* File: src/psc_top.v */
// page select and crc result register bank with host address resolution
//
// Summary of operation
// - override set: page number supplies register address bits A5 and A4.
// - override set: low address bits come from pins or latch per interface.
// - override clear: whole address comes from the internal latch.
// - page register bits 6..2 read zero; host writes zeros there.
// - crc result shown as separate read-only high and low byte registers.
// - reverse option flips bits inside each crc byte, bytes stay put.
// - low crc byte register follows crc low byte one clock later, read-only.
//
// Added by the designer: the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`default_nettype none
`include "psc_map.vh"

module psc_top (
  input  wire                     aclk,
  input  wire                     aresetn,
  input  wire [`PSC_AXI_AW-1:0]   s_axi_awaddr,
  input  wire                     s_axi_awvalid,
  output wire                     s_axi_awready,
  input  wire [31:0]              s_axi_wdata,
  input  wire [3:0]               s_axi_wstrb,
  input  wire                     s_axi_wvalid,
  output wire                     s_axi_wready,
  output wire [1:0]               s_axi_bresp,
  output wire                     s_axi_bvalid,
  input  wire                     s_axi_bready,
  input  wire [`PSC_AXI_AW-1:0]   s_axi_araddr,
  input  wire                     s_axi_arvalid,
  output wire                     s_axi_arready,
  output wire [31:0]              s_axi_rdata,
  output wire [1:0]               s_axi_rresp,
  output wire                     s_axi_rvalid,
  input  wire                     s_axi_rready,
  input  wire [15:0]              crc_value,
  input  wire                     crc_done_flag,
  input  wire [`PSC_ADDR_W-1:0]   host_addr_pins,
  input  wire [`PSC_ADDR_W-1:0]   addr_latch,
  input  wire                     host_uses_pins,
  input  wire                     host_access,
  output reg  [`PSC_ADDR_W-1:0]   reg_addr_r,
  output reg                      reg_addr_valid_r,
  output reg                      page_override_enable_r,
  output reg  [1:0]               page_number_r,
  output reg                      bit_order_reverse_r,
  output wire [7:0]               crc_high_byte,
  output wire [7:0]               crc_low_byte,
  output reg                      irq_r
);

  // decode helper shared by the read and write paths
  localparam [3:0] SEL_NONE   = 4'd0;
  localparam [3:0] SEL_PAGE   = 4'd1;
  localparam [3:0] SEL_CRC_HI = 4'd2;
  localparam [3:0] SEL_CRC_LO = 4'd3;
  localparam [3:0] SEL_CONFIG = 4'd4;
  localparam [3:0] SEL_STATUS = 4'd5;
  localparam [3:0] SEL_ISTAT  = 4'd6;
  localparam [3:0] SEL_IMASK  = 4'd7;

  // reset words kept whole so single fields can be picked out at full width
  localparam [7:0] PAGE_RST   = `PSC_PAGE_RST;
  localparam [7:0] CFG_RST    = `PSC_CFG_RST;

  function [3:0] reg_sel;
    input [`PSC_AXI_AW-1:0] addr;
    reg   [7:0]             idx;
    begin
      idx = addr[9:2];
      if (addr[`PSC_AXI_AW-1:10] != 2'b00) begin
        reg_sel = SEL_NONE;
      end else begin
        case (idx)
          `PSC_IDX_PAGE:     reg_sel = SEL_PAGE;
          `PSC_IDX_CRC_HI:   reg_sel = SEL_CRC_HI;
          `PSC_IDX_CRC_LO:   reg_sel = SEL_CRC_LO;
          `PSC_IDX_CONFIG:   reg_sel = SEL_CONFIG;
          `PSC_IDX_STATUS:   reg_sel = SEL_STATUS;
          `PSC_IDX_IRQ_STAT: reg_sel = SEL_ISTAT;
          `PSC_IDX_IRQ_MASK: reg_sel = SEL_IMASK;
          default:           reg_sel = SEL_NONE;
        endcase
      end
    end
  endfunction

  wire                   wr_en;
  wire [`PSC_AXI_AW-1:0] wr_addr;
  wire [31:0]            wr_data;
  wire [3:0]             wr_strb;
  wire [`PSC_AXI_AW-1:0] rd_addr;
  reg  [31:0]            rd_data;
  reg                    rd_ok;
  reg                    wr_ok;
  wire [3:0]             wr_sel;
  wire [3:0]             rd_sel;
  wire                   wr_lane0;

  reg  [`PSC_ADDR_W-1:0] pins_meta_r;
  reg  [`PSC_ADDR_W-1:0] pins_sync_r;
  reg  [`PSC_EV_W-1:0]   irq_stat_r;
  reg  [`PSC_EV_W-1:0]   irq_mask_r;
  reg  [`PSC_EV_W-1:0]   irq_stat_nxt;
  reg  [`PSC_EV_W-1:0]   ev_set;
  reg                    crc_done_d_r;
  reg  [`PSC_ADDR_W-1:0] reg_addr_nxt;
  reg  [`PSC_LOW_ADDR_W-1:0] low_addr;

  assign wr_sel   = reg_sel(wr_addr);
  assign rd_sel   = reg_sel(rd_addr);
  assign wr_lane0 = wr_strb[0];

  psc_axil_slave u_bus (
    .aclk          (aclk),
    .aresetn       (aresetn),
    .s_axi_awaddr  (s_axi_awaddr),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_wdata   (s_axi_wdata),
    .s_axi_wstrb   (s_axi_wstrb),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_araddr  (s_axi_araddr),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_rresp   (s_axi_rresp),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready),
    .wr_en         (wr_en),
    .wr_addr_r     (wr_addr),
    .wr_data_r     (wr_data),
    .wr_strb_r     (wr_strb),
    .wr_ok         (wr_ok),
    .rd_addr_r     (rd_addr),
    .rd_data       (rd_data),
    .rd_ok         (rd_ok)
  );

  psc_crc_view u_crc (
    .aclk              (aclk),
    .aresetn           (aresetn),
    .crc_value         (crc_value),
    .bit_order_reverse (bit_order_reverse_r),
    .crc_high_byte_r   (crc_high_byte),
    .crc_low_byte_r    (crc_low_byte)
  );

  // writes to the read-only crc and status words are refused with slverr
  always @* begin
    case (wr_sel)
      SEL_PAGE:   wr_ok = 1'b1;
      SEL_CONFIG: wr_ok = 1'b1;
      SEL_ISTAT:  wr_ok = 1'b1;
      SEL_IMASK:  wr_ok = 1'b1;
      SEL_CRC_HI: wr_ok = 1'b0;
      SEL_CRC_LO: wr_ok = 1'b0;
      default:    wr_ok = 1'b0;
    endcase
  end

  // page register, configuration and interrupt mask; reserved page bits are never stored
  always @(posedge aclk) begin
    if (!aresetn) begin
      page_override_enable_r <= PAGE_RST[`PSC_PAGE_OVR_BIT];
      page_number_r          <= PAGE_RST[`PSC_PAGE_NUM_HI:`PSC_PAGE_NUM_LO];
      bit_order_reverse_r    <= CFG_RST[`PSC_CFG_REV_BIT];
      irq_mask_r             <= `PSC_EV_RST;
    end else if (wr_en && wr_lane0) begin
      if (wr_sel == SEL_PAGE) begin
        page_override_enable_r <= wr_data[`PSC_PAGE_OVR_BIT];
        page_number_r <= wr_data[`PSC_PAGE_NUM_HI:`PSC_PAGE_NUM_LO];
      end
      if (wr_sel == SEL_CONFIG) begin
        bit_order_reverse_r <= wr_data[`PSC_CFG_REV_BIT];
      end
      if (wr_sel == SEL_IMASK) begin
        irq_mask_r <= wr_data[`PSC_EV_W-1:0];
      end
    end
  end

  // read mux; every word is one byte wide, upper bits read zero
  always @* begin
    rd_data = 32'h0000_0000;
    rd_ok   = 1'b1;
    case (rd_sel)
      SEL_PAGE: begin
        rd_data[`PSC_PAGE_OVR_BIT] = page_override_enable_r;
        rd_data[`PSC_PAGE_NUM_HI:`PSC_PAGE_NUM_LO] = page_number_r;
      end
      SEL_CRC_HI: rd_data[7:0] = crc_high_byte;
      SEL_CRC_LO: rd_data[7:0] = crc_low_byte;
      SEL_CONFIG: rd_data[`PSC_CFG_REV_BIT] = bit_order_reverse_r;
      SEL_STATUS: rd_data[`PSC_STAT_DONE_BIT] = crc_done_flag;
      SEL_ISTAT:  rd_data[`PSC_EV_W-1:0] = irq_stat_r;
      SEL_IMASK:  rd_data[`PSC_EV_W-1:0] = irq_mask_r;
      default:    rd_ok = 1'b0;
    endcase
  end

  // address pins come from outside the clock domain
  always @(posedge aclk) begin
    if (!aresetn) begin
      pins_meta_r <= {`PSC_ADDR_W{1'b0}};
      pins_sync_r <= {`PSC_ADDR_W{1'b0}};
    end else begin
      pins_meta_r <= host_addr_pins;
      pins_sync_r <= pins_meta_r;
    end
  end

  // register address resolution for each host access
  always @* begin
    low_addr = host_uses_pins ? pins_sync_r[`PSC_LOW_ADDR_W-1:0]
                              : addr_latch[`PSC_LOW_ADDR_W-1:0];
    if (page_override_enable_r) begin
      reg_addr_nxt = {page_number_r, low_addr};
    end else begin
      reg_addr_nxt = addr_latch;
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      reg_addr_r       <= {`PSC_ADDR_W{1'b0}};
      reg_addr_valid_r <= 1'b0;
    end else begin
      reg_addr_valid_r <= host_access;
      if (host_access) begin
        reg_addr_r <= reg_addr_nxt;
      end
    end
  end

  // sticky events; a new event in the clearing cycle survives the clear
  always @* begin
    ev_set = `PSC_EV_RST;
    ev_set[`PSC_EV_CRC_DONE] = crc_done_flag & ~crc_done_d_r;
    ev_set[`PSC_EV_PAGED]    = host_access & page_override_enable_r;
    irq_stat_nxt = irq_stat_r;
    if (wr_en && wr_lane0 && wr_sel == SEL_ISTAT) begin
      irq_stat_nxt = irq_stat_nxt & ~wr_data[`PSC_EV_W-1:0];
    end
    irq_stat_nxt = irq_stat_nxt | ev_set;
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      crc_done_d_r <= 1'b0;
      irq_stat_r   <= `PSC_EV_RST;
      irq_r        <= 1'b0;
    end else begin
      crc_done_d_r <= crc_done_flag;
      irq_stat_r   <= irq_stat_nxt;
      irq_r        <= |(irq_stat_nxt & irq_mask_r);
    end
  end

endmodule
`default_nettype wire

/* File: bench/psc_top_sva.sv */
// port assertions for the page select and crc result bank
`timescale 1ns/100ps
`default_nettype none
module psc_top_sva (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic [15:0] crc_value,
  input wire logic [5:0]  addr_latch,
  input wire logic        host_uses_pins,
  input wire logic        host_access,
  input wire logic [5:0]  reg_addr_r,
  input wire logic        reg_addr_valid_r,
  input wire logic        page_override_enable_r,
  input wire logic [1:0]  page_number_r,
  input wire logic        bit_order_reverse_r,
  input wire logic [7:0]  crc_high_byte,
  input wire logic [7:0]  crc_low_byte
);
  function automatic logic [7:0] rev8(input logic [7:0] v);
    for (int k = 0; k < 8; k++) rev8[k] = v[7-k];
  endfunction
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_addr_whole: assert property (
    host_access && !page_override_enable_r
    |=> reg_addr_valid_r && reg_addr_r == $past(addr_latch))
    else $error("address not taken whole from latch");
  a_page_bits: assert property (
    host_access && page_override_enable_r
    |=> reg_addr_r[5:4] == $past(page_number_r))
    else $error("page number not on upper address bits");
  a_latch_low: assert property (
    host_access && page_override_enable_r && !host_uses_pins
    |=> reg_addr_r[3:0] == $past(addr_latch[3:0]))
    else $error("low address bits not from latch");
  a_crc_plain: assert property (
    $past(aresetn) && !$past(bit_order_reverse_r)
    |-> {crc_high_byte, crc_low_byte} == $past(crc_value))
    else $error("crc bytes do not follow crc value");
  a_crc_rev: assert property (
    $past(aresetn) && $past(bit_order_reverse_r)
    |-> crc_low_byte == rev8($past(crc_value[7:0]))
    && crc_high_byte == rev8($past(crc_value[15:8])))
    else $error("crc bytes not bit reversed");
  a_rd_answer: assert property (
    s_axi_arvalid && s_axi_arready |-> ##[1:3] s_axi_rvalid)
    else $error("read answer late");
  a_rd_hold: assert property (
    s_axi_rvalid |=> $past(s_axi_rready) ? !s_axi_rvalid
                     : (s_axi_rvalid && $stable(s_axi_rdata)))
    else $error("read answer not held until taken or kept after");
  a_wr_hold: assert property (
    s_axi_bvalid |=> $past(s_axi_bready) ? !s_axi_bvalid
                     : (s_axi_bvalid && $stable(s_axi_bresp)))
    else $error("write answer not held until taken or kept after");
  c_paged: cover property (host_access && page_override_enable_r);
  c_rev: cover property (bit_order_reverse_r && $changed(crc_value));
  c_err: cover property (s_axi_bvalid && s_axi_bresp == 2'b10);
endmodule
`default_nettype wire

/* File: bench/psc_host_model.sv */
// host side model: drives the address resolution lines of the bank
`timescale 1ns/100ps
`default_nettype none
module psc_host_model (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       go,
  input  wire logic [5:0] lat,
  input  wire logic [5:0] pins,
  input  wire logic       use_pins,
  output logic            host_access,
  output logic [5:0]      addr_latch,
  output logic [5:0]      host_addr_pins,
  output logic            host_uses_pins
);
  // lines move only after an edge, so the pin synchroniser sees clean steps
  always @(posedge aclk) begin
    if (!aresetn) begin
      host_access    <= 1'b0;
      addr_latch     <= 6'h00;
      host_addr_pins <= 6'h00;
      host_uses_pins <= 1'b0;
    end else begin
      host_access    <= go;
      addr_latch     <= lat;
      host_addr_pins <= pins;
      host_uses_pins <= use_pins;
    end
  end
endmodule
`default_nettype wire

/* File: bench/page_select_and_crc_result_tb.sv */
// self-checking bench for the page select and crc result bank
`timescale 1ns/100ps
`default_nettype none
`include "psc_map.vh"
module page_select_and_crc_result_tb;
  logic aclk = 1'b0, aresetn = 1'b0, crc_done_flag = 1'b0;
  logic [`PSC_AXI_AW-1:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, go = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [15:0] crc_value = 16'h0000;
  logic [5:0] lat = 6'h00, pins = 6'h00, host_addr_pins, addr_latch, reg_addr_r;
  logic use_pins = 1'b0, host_uses_pins, host_access, reg_addr_valid_r, irq_r;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic page_override_enable_r, bit_order_reverse_r;
  logic [1:0] s_axi_bresp, s_axi_rresp, page_number_r;
  logic [7:0] crc_high_byte, crc_low_byte;
  int bad_count = 0, n_checks = 0, mdl[int], wm[int];
  psc_top u_psc_top (.*);
  psc_host_model u_psc_host_model (.*);
  initial begin
    forever #5 aclk = ~aclk;
  end
  function automatic logic [7:0] rev8(input logic [7:0] v);
    for (int k = 0; k < 8; k++) rev8[k] = v[7-k];
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic reg_wr(input int i, input int d);
    s_axi_awaddr <= 12'(i * 4);
    s_axi_wdata <= 32'(d);
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    // ready stays up between transfers, so the answer is taken as it is seen
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    chk(s_axi_bresp, wm.exists(i) ? 2'b00 : 2'b10);
    if (wm.exists(i)) mdl[i] = (i == 8'h32) ? mdl[i] & ~d : d & wm[i];
  endtask
  task automatic reg_rd(input int i);
    s_axi_araddr <= 12'(i * 4);
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    chk(s_axi_rresp, mdl.exists(i) ? 2'b00 : 2'b10);
    chk(s_axi_rdata, mdl.exists(i) ? mdl[i] : 0);
  endtask
  task automatic put_crc(input int v);
    logic [7:0] h, l;
    crc_value <= 16'(v);
    repeat (2) @(posedge aclk);
    h = v[15:8];
    l = v[7:0];
    if (mdl[8'h30][0]) begin
      h = rev8(h);
      l = rev8(l);
    end
    mdl[8'h21] = h;
    mdl[8'h22] = l;
    chk(crc_high_byte, h);
    chk(crc_low_byte, l);
  endtask
  task automatic resolve(input int o, input int p);
    logic [5:0] e;
    lat <= 6'($urandom);
    pins <= 6'($urandom);
    use_pins <= 1'($urandom);
    reg_wr(8'h20, {o[0], 5'h00, p[1:0]});
    repeat (4) @(posedge aclk);
    go <= 1'b1;
    @(posedge aclk);
    go <= 1'b0;
    repeat (2) @(posedge aclk);
    e = o[0] ? {p[1:0], use_pins ? pins[3:0] : lat[3:0]} : lat;
    if (o[0]) mdl[8'h32] |= 2;
    chk(page_override_enable_r, o[0]);
    chk(reg_addr_valid_r, 1'b1);
    chk(reg_addr_r, e);
  endtask
  task automatic pulse_done(input logic en);
    crc_done_flag <= 1'b0;
    repeat (2) @(posedge aclk);
    crc_done_flag <= 1'b1;
    repeat (4) @(posedge aclk);
    mdl[8'h31] = 1;
    mdl[8'h32] |= 1;
    chk(irq_r, en);
    reg_rd(8'h32);
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge aclk);
    bad_count++;
    complete_run;
  end
  initial begin
    void'($urandom(53));
    foreach (wm[i]) wm.delete(i);
    for (int i = 8'h20; i < 8'h34; i++) if (i < 8'h23 || i > 8'h2f) mdl[i] = 0;
    wm[8'h20] = 8'h83;
    wm[8'h30] = 1;
    wm[8'h32] = 3;
    wm[8'h33] = 3;
    repeat (5) @(posedge aclk);
    chk(crc_high_byte, 8'hff);
    chk(crc_low_byte, 8'hff);
    aresetn <= 1'b1;
    @(posedge aclk);
    foreach (mdl[i]) reg_rd(i);
    reg_wr(8'h20, 8'hff);
    reg_rd(8'h20);
    reg_wr(8'h21, 8'h00);
    reg_wr(8'h22, 8'h00);
    reg_wr(8'h2f, 8'h01);
    reg_rd(8'hff);
    $display("test reset_map done");
    // the host trusts the crc bytes only once done is high
    pulse_done(1'b0);
    for (int k = 0; k < 8; k++) begin
      reg_wr(8'h30, k);
      put_crc($urandom);
      reg_rd(8'h21);
      reg_rd(8'h22);
    end
    $display("test crc_view done");
    for (int k = 0; k < 12; k++) resolve($urandom, $urandom);
    $display("test resolve done");
    reg_wr(8'h33, 8'h01);
    reg_wr(8'h32, 8'h03);
    chk(irq_r, 1'b0);
    pulse_done(1'b1);
    reg_rd(8'h31);
    reg_wr(8'h32, 8'h01);
    chk(irq_r, 1'b0);
    reg_wr(8'h33, 8'h00);
    reg_rd(8'h33);
    pulse_done(1'b0);
    $display("test irq done");
    complete_run;
  end
endmodule
bind psc_top psc_top_sva u_psc_top_sva (.*);
`default_nettype wire
